// >>> lsd_pkg.sv
// Package for the low-power SDRAM command and refresh sequencer.
// Assumes a single 40 MHz clock and commands decoded from the pins each edge.
package lsd_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_PS         = 25000;
  localparam int AP_START_FAST_PS      = 7500;
  localparam int AP_START_SLOW_PS      = 7000;
  localparam int WRITE_RECOVERY_PS     = 15000;
  localparam int REFRESH_CYCLE_PS      = 80000;
  localparam int PRECHARGE_PERIOD_PS   = 22500;
  localparam int SREF_TICK_NS          = 15625;
  // Least times round up, at least one cycle
  localparam int AP_START_FAST_CYC     = (AP_START_FAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AP_START_SLOW_CYC     = (AP_START_SLOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_RECOVERY_CYC    = (WRITE_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFRESH_CYCLE_CYC     = (REFRESH_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRECHARGE_PERIOD_CYC  = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SREF_TICK_CYC         = (SREF_TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W                 = 16;
  localparam int ROW_W                 = 12;
  localparam int BANK_W                = 2;
  localparam int NUM_BANKS             = 4;
  localparam int COL_W                 = 9;
  localparam int COL_IGNORE_LO         = 9;
  localparam int COL_IGNORE_HI         = 11;
  localparam logic [ROW_W-1:0] ROW_RESET = 12'h000;
  // ==========================================================================
  // Commands
  typedef enum logic [2:0]
  {
    LSD_CMD_NOP,
    LSD_CMD_ACTIVE,
    LSD_CMD_READ,
    LSD_CMD_WRITE,
    LSD_CMD_PRECHARGE,
    LSD_CMD_REFRESH,
    LSD_CMD_MODE,
    LSD_CMD_STOP
  } lsd_cmd_t;

  typedef struct packed
  {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  addr;
  } lsd_pins_t;

  typedef struct packed
  {
    logic              valid;
    logic              is_write;
    logic              auto_pre;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
  } lsd_col_t;
endpackage : lsd_pkg

// >>> lsd_refresh_engine.sv
// Internal refresh engine: row address counter and self refresh oscillator.
// Assumes refresh requests arrive as one-cycle pulses from the sequencer.
`timescale 1ns/10ps
module lsd_refresh_engine
#(
  parameter int TICK_CYC = lsd_pkg::SREF_TICK_CYC,
  parameter int BUSY_CYC = lsd_pkg::REFRESH_CYCLE_CYC
)
(
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic                     auto_req,
  input  wire logic                     self_mode,
  output logic                          busy,
  output logic [lsd_pkg::ROW_W-1:0]     row,
  output logic [lsd_pkg::CNT_W-1:0]     count
);
  import lsd_pkg::*;

  logic [CNT_W-1:0] osc_q;
  logic [CNT_W-1:0] osc_d;
  logic [CNT_W-1:0] busy_cnt_q;
  logic [CNT_W-1:0] busy_cnt_d;
  logic [ROW_W-1:0] row_q;
  logic [CNT_W-1:0] count_q;
  wire              osc_tick;
  wire              start;

  // ==========================================================================
  // Oscillator and start
  assign osc_tick   = self_mode && (osc_q == CNT_W'(TICK_CYC - 1));
  assign start      = (auto_req || osc_tick) && (busy_cnt_q == '0);
  assign osc_d      = (!self_mode || osc_tick) ? '0 : osc_q + CNT_W'(1);
  assign busy_cnt_d = start ? CNT_W'(BUSY_CYC) :
                      (busy_cnt_q != '0) ? busy_cnt_q - CNT_W'(1) : '0;

  // ==========================================================================
  // State
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      osc_q      <= '0;
      busy_cnt_q <= '0;
      row_q      <= ROW_RESET;
      count_q    <= '0;
    end
    else
    begin
      osc_q      <= osc_d;
      busy_cnt_q <= busy_cnt_d;
      if (start)
      begin
        row_q   <= row_q + ROW_W'(1);
        count_q <= count_q + CNT_W'(1);
      end
    end
  end

  assign busy  = (busy_cnt_q != '0);
  assign row   = row_q;
  assign count = count_q;
endmodule : lsd_refresh_engine

// >>> lsd_sequencer.sv
// Decodes the command pins, tracks bank state, auto precharge and refresh.
// Assumes pins are synchronous to clk_sys; controller keeps its own timings.
`timescale 1ns/10ps
module lsd_sequencer
#(
  parameter bit FAST_GRADE = 1'b1
)
(
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  input  wire lsd_pkg::lsd_pins_t            pins,
  output lsd_pkg::lsd_col_t                  col_cmd,
  output logic [lsd_pkg::NUM_BANKS-1:0]      bank_open,
  output logic [lsd_pkg::NUM_BANKS-1:0]      bank_precharging,
  output logic                               self_refresh,
  output logic                               power_down,
  output logic                               refresh_busy,
  output logic [lsd_pkg::ROW_W-1:0]          refresh_row,
  output logic [lsd_pkg::CNT_W-1:0]          refresh_count
);
  import lsd_pkg::*;

  localparam int AP_CYC = FAST_GRADE ? AP_START_FAST_CYC : AP_START_SLOW_CYC;

  typedef enum logic [1:0] {LSD_ST_IDLE, LSD_ST_ACTIVE, LSD_ST_PRECHARGE} lsd_bank_st_t;

  // ==========================================================================
  // Functions
  function automatic lsd_cmd_t lsd_decode(input lsd_pins_t p);
    if (p.cs_n)
      return LSD_CMD_NOP;
    unique case ({p.ras_n, p.cas_n, p.we_n})
      3'b011:  return LSD_CMD_ACTIVE;
      3'b101:  return LSD_CMD_READ;
      3'b100:  return LSD_CMD_WRITE;
      3'b010:  return LSD_CMD_PRECHARGE;
      3'b001:  return LSD_CMD_REFRESH;
      3'b000:  return LSD_CMD_MODE;
      3'b110:  return LSD_CMD_STOP;
      default: return LSD_CMD_NOP;
    endcase
  endfunction : lsd_decode

  function automatic logic [CNT_W-1:0] lsd_dec(input logic [CNT_W-1:0] c);
    return (c != '0) ? c - CNT_W'(1) : '0;
  endfunction : lsd_dec

  // ==========================================================================
  // Decode
  lsd_cmd_t         cmd;
  wire              cke_fall;
  wire              is_refresh;
  wire              is_self_entry;
  wire              wr_col;
  wire [COL_W-1:0]  col_addr;
  wire              ap_flag;
  wire              pre_all;
  logic             cke_q;
  logic             self_q;
  logic             pd_q;
  lsd_col_t         col_q;
  lsd_bank_st_t     bst_q [NUM_BANKS];
  logic [CNT_W-1:0] pre_cnt_q [NUM_BANKS];
  logic [CNT_W-1:0] ap_cnt_q  [NUM_BANKS];
  logic             ap_pend_q [NUM_BANKS];
  wire              eng_busy;

  assign cmd           = lsd_decode(pins);
  assign cke_fall      = cke_q && !pins.cke;
  assign is_refresh    = (cmd == LSD_CMD_REFRESH) && cke_q && pins.cke;
  assign is_self_entry = (cmd == LSD_CMD_REFRESH) && cke_fall;
  assign wr_col        = (cmd == LSD_CMD_WRITE);
  // Column bits above A8 are dropped; A9 and A11 never reach the array
  assign col_addr      = pins.addr[COL_W-1:0];
  assign ap_flag       = pins.addr[10];
  assign pre_all       = pins.addr[10];

  // ==========================================================================
  // Refresh engine
  lsd_refresh_engine u_refresh
  (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .auto_req  (is_refresh),
    .self_mode (self_q),
    .busy      (eng_busy),
    .row       (refresh_row),
    .count     (refresh_count)
  );

  // ==========================================================================
  // Power state
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cke_q        <= 1'b1;
      self_q       <= 1'b0;
      pd_q         <= 1'b0;
      col_q        <= '0;
      refresh_busy <= 1'b0;
    end
    else
    begin
      cke_q        <= pins.cke;
      refresh_busy <= eng_busy;
      if (is_self_entry)
        self_q <= 1'b1;
      else if (pins.cke)
        self_q <= 1'b0;
      if (cke_fall && !is_self_entry)
        pd_q <= 1'b1;
      else if (pins.cke)
        pd_q <= 1'b0;
      col_q.valid    <= pins.cke && cke_q && (wr_col || cmd == LSD_CMD_READ);
      col_q.is_write <= wr_col;
      col_q.auto_pre <= ap_flag;
      col_q.bank     <= pins.bank;
      col_q.col      <= col_addr;
    end
  end

  // ==========================================================================
  // Bank state and auto precharge
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    wire hit     = (pins.bank == BANK_W'(b));
    wire live    = pins.cke && cke_q;
    wire act     = live && (cmd == LSD_CMD_ACTIVE) && hit;
    wire pre     = live && (cmd == LSD_CMD_PRECHARGE) && (hit || pre_all);
    wire colap   = live && (cmd == LSD_CMD_READ || wr_col) && hit && ap_flag;
    // Write recovery plus start delay for writes, start delay alone for reads, before the internal precharge begins
    wire [CNT_W-1:0] ap_load = wr_col ? CNT_W'(WRITE_RECOVERY_CYC + AP_CYC)
                                      : CNT_W'(AP_CYC);
    wire ap_fire = ap_pend_q[b] && (ap_cnt_q[b] == '0);

    always_ff @(posedge clk_sys)
    begin
      if (!rstn)
      begin
        bst_q[b]     <= LSD_ST_IDLE;
        pre_cnt_q[b] <= '0;
        ap_cnt_q[b]  <= '0;
        ap_pend_q[b] <= 1'b0;
      end
      else
      begin
        ap_cnt_q[b] <= colap ? ap_load : lsd_dec(ap_cnt_q[b]);
        if (colap)
          ap_pend_q[b] <= 1'b1;
        else if (ap_fire)
          ap_pend_q[b] <= 1'b0;
        unique case (bst_q[b])
          LSD_ST_IDLE:
            if (act)
              bst_q[b] <= LSD_ST_ACTIVE;
          LSD_ST_ACTIVE:
            if (pre || ap_fire)
            begin
              bst_q[b]     <= LSD_ST_PRECHARGE;
              pre_cnt_q[b] <= CNT_W'(PRECHARGE_PERIOD_CYC);
            end
          LSD_ST_PRECHARGE:
          begin
            pre_cnt_q[b] <= lsd_dec(pre_cnt_q[b]);
            if (pre_cnt_q[b] <= CNT_W'(1))
              bst_q[b] <= LSD_ST_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge clk_sys)
    begin
      if (!rstn)
      begin
        bank_open[b]        <= 1'b0;
        bank_precharging[b] <= 1'b0;
      end
      else
      begin
        bank_open[b]        <= (bst_q[b] == LSD_ST_ACTIVE);
        bank_precharging[b] <= (bst_q[b] == LSD_ST_PRECHARGE);
      end
    end
  end

  assign col_cmd      = col_q;
  assign self_refresh = self_q;
  assign power_down   = pd_q;
endmodule : lsd_sequencer

// >>> lsd_sequencer_asserts.sv
// Checker for the command sequencer ports.
// Assumes it is bound to lsd_sequencer with the default grade.
`timescale 1ns/10ps
module lsd_sequencer_asserts
(
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire lsd_pkg::lsd_pins_t pins,
  input wire lsd_pkg::lsd_col_t  col_cmd,
  input wire logic [3:0]         bank_open,
  input wire logic [3:0]         bank_precharging,
  input wire logic               self_refresh,
  input wire logic               power_down,
  input wire logic               refresh_busy,
  input wire logic [11:0]        refresh_row,
  input wire logic [15:0]        refresh_count
);
  import lsd_pkg::*;
  localparam int TICK_LIM = SREF_TICK_CYC + 8;
  logic        cke_q;
  logic [15:0] t_q;
  wire live  = !pins.cs_n && pins.cke && cke_q;
  wire rw_go = live && pins.ras_n && !pins.cas_n;
  wire rf_go = live && !pins.ras_n && !pins.cas_n && pins.we_n;
  wire sr_go = !pins.cs_n && cke_q && !pins.cke && !pins.ras_n && !pins.cas_n && pins.we_n;
  wire pd_go = cke_q && !pins.cke && !sr_go;
  // ====================
  // Helpers
  always_ff @(posedge clk_sys)
  begin
    cke_q <= rstn ? pins.cke : 1'b1;
    t_q   <= (!rstn || !self_refresh || $changed(refresh_count)) ? 16'h0 : t_q + 16'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ====================
  // Properties
  col_field_a: assert property (col_cmd.valid |-> $past(rw_go)
    && col_cmd.col == $past(pins.addr[8:0]) && col_cmd.bank == $past(pins.bank))
    else $error("column fields wrong");
  col_issue_a: assert property (rw_go |=> col_cmd.valid && col_cmd.is_write == !$past(pins.we_n)
    && col_cmd.auto_pre == $past(pins.addr[10])) else $error("column command lost");
  ap_start_a: assert property (col_cmd.valid && col_cmd.is_write && col_cmd.auto_pre
    |-> ##[1:4] (|bank_precharging)) else $error("auto precharge missing");
  ref_take_a: assert property (rf_go && !refresh_busy && !$past(rf_go)
    |=> refresh_count == $past(refresh_count) + 16'h1) else $error("refresh not counted");
  count_step_a: assert property ($changed(refresh_count) |->
    refresh_count == $past(refresh_count) + 16'h1 && refresh_row == $past(refresh_row) + 12'h1)
    else $error("refresh step wrong");
  sref_tick_a: assert property (t_q <= TICK_LIM) else $error("self refresh stalled");
  sref_entry_a: assert property (sr_go |=> self_refresh) else $error("self refresh not entered");
  sref_exit_a: assert property (self_refresh && pins.cke |=> !self_refresh)
    else $error("self refresh not left");
  pd_entry_a: assert property (pd_go |=> power_down) else $error("power-down not entered");
  busy_follow_a: assert property (rf_go && !refresh_busy && !$past(rf_go)
    |=> ##1 refresh_busy) else $error("refresh busy not raised");
  c_ref: cover property (rf_go);
  c_sref: cover property (sr_go);
  c_ap: cover property (col_cmd.valid && col_cmd.auto_pre);
endmodule : lsd_sequencer_asserts

bind lsd_sequencer lsd_sequencer_asserts i_lsd_sequencer_asserts (.clk_sys(clk_sys),
  .rstn(rstn), .pins(pins), .col_cmd(col_cmd), .bank_open(bank_open),
  .bank_precharging(bank_precharging), .self_refresh(self_refresh), .power_down(power_down),
  .refresh_busy(refresh_busy), .refresh_row(refresh_row), .refresh_count(refresh_count));

// >>> lsd_ctrl_model.sv
// Controller model driving the command pins with legal spacing, or with bare gaps when rude is set.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
module lsd_ctrl_model
#(
  parameter int INIT_CYC = 4000,
  parameter int RAS_CYC  = 4
)
(
  input  wire logic          clk_sys,
  output lsd_pkg::lsd_pins_t pins
);
  import lsd_pkg::*;
  initial pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 12'h000};
  // ====================
  // Commands
  task automatic cmd(input lsd_cmd_t c, input logic [1:0] b, input logic [11:0] a,
                     input logic ke, input int gap, input bit rude);
    logic [3:0] o;
    int         m;
    o = (c == LSD_CMD_ACTIVE) ? 4'h3 : (c == LSD_CMD_READ) ? 4'h5 : (c == LSD_CMD_WRITE) ? 4'h4
      : (c == LSD_CMD_PRECHARGE) ? 4'h2 : (c == LSD_CMD_REFRESH) ? 4'h1
      : (c == LSD_CMD_MODE) ? 4'h0 : 4'h7;
    m = (c == LSD_CMD_REFRESH) ? REFRESH_CYCLE_CYC
      : (c == LSD_CMD_ACTIVE) ? RAS_CYC
      : (c == LSD_CMD_WRITE) ? WRITE_RECOVERY_CYC + 1
      : 2;
    @(posedge clk_sys);
    pins <= '{o[3], o[2], o[1], o[0], ke, b, a};
    repeat (rude ? gap : (gap > m ? gap : m))
    begin
      @(posedge clk_sys);
      pins.cs_n <= 1'b1;
      pins.bank <= ~pins.bank;
      pins.addr <= ~pins.addr;
    end
  endtask : cmd
  task automatic wake;
    repeat (INIT_CYC) @(posedge clk_sys);
    cmd(LSD_CMD_REFRESH, 2'h0, 12'h000, 1'b1, 0, 1'b0);
    cmd(LSD_CMD_REFRESH, 2'h0, 12'h000, 1'b1, 0, 1'b0);
  endtask : wake
endmodule : lsd_ctrl_model

// >>> lsd_sequencer_test.sv
// Bench for lsd_sequencer: wake-up, column traffic, refresh, low-power modes.
// Assumes lsd_ctrl_model drives the pins and the checker is bound.
`timescale 1ns/10ps
module lsd_sequencer_test;
  import lsd_pkg::*;
  logic        clk_sys;
  logic        rstn;
  lsd_pins_t   pins;
  lsd_col_t    col_cmd;
  lsd_col_t    seen_col;
  logic [3:0]  bank_open;
  logic [3:0]  bank_precharging;
  logic        self_refresh;
  logic        power_down;
  logic        refresh_busy;
  logic [11:0] refresh_row;
  logic [15:0] refresh_count;
  logic [15:0] c0;
  int          err_total;
  int          n_compared;
  lsd_sequencer i_lsd_sequencer (.clk_sys(clk_sys), .rstn(rstn), .pins(pins),
    .col_cmd(col_cmd), .bank_open(bank_open), .bank_precharging(bank_precharging),
    .self_refresh(self_refresh), .power_down(power_down), .refresh_busy(refresh_busy),
    .refresh_row(refresh_row), .refresh_count(refresh_count));
  lsd_ctrl_model i_lsd_ctrl_model (.clk_sys(clk_sys), .pins(pins));
  // ====================
  // Helpers
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (col_cmd.valid === 1'b1) seen_col <= col_cmd;
  function automatic lsd_col_t exp_col(input logic [11:0] a, input logic [1:0] b, input logic w);
    exp_col = '{1'b1, w, a[10], b, a[8:0]};
  endfunction : exp_col
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic go(input lsd_cmd_t c, input logic [1:0] b, input logic [11:0] a,
                    input logic ke, input int gap, input bit rude);
    i_lsd_ctrl_model.cmd(c, b, a, ke, gap, rude);
  endtask : go
  task automatic idle;
    int k;
    for (k = 0; k < 20 && bank_open !== 4'h0; k++)
      @(posedge clk_sys);
    if (k == 20)
    begin
      err_total++;
      complete_run();
    end
  endtask : idle
  // ====================
  // Main sequence
  initial
  begin
    logic [11:0] a;
    logic [1:0]  b;
    logic        w;
    err_total = 0;
    n_compared = 0;
    rstn = 1'b0;
    void'($urandom(32'h65149d9c));
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    check({col_cmd, bank_open, bank_precharging, self_refresh, power_down, refresh_count}, 0);
    $display("reset done");
    i_lsd_ctrl_model.wake();
    check({refresh_row, refresh_count}, {12'h002, 16'h0002});
    go(LSD_CMD_MODE, 2'h0, 12'h020, 1'b1, 0, 1'b0);
    $display("wake-up done");
    for (int i = 0; i < 8; i++)
    begin
      b = 2'($urandom);
      a = (i < 2) ? (i ? 12'hfff : 12'ha00) : 12'($urandom);
      w = (i < 2) || ($urandom % 2);
      go(LSD_CMD_ACTIVE, b, 12'($urandom), 1'b1, 0, 1'b0);
      check(bank_open[b], 1'b1);
      go(w ? LSD_CMD_WRITE : LSD_CMD_READ, b, a, 1'b1, 3, 1'b0);
      check(seen_col, exp_col(a, b, w));
      if (!a[10])
        go(LSD_CMD_PRECHARGE, b, 12'h000, 1'b1, 0, 1'b0);
      idle();
      check(bank_open, 4'h0);
    end
    $display("column traffic done");
    c0 = refresh_count;
    go(LSD_CMD_REFRESH, 2'h0, 12'h000, 1'b1, 0, 1'b1);
    go(LSD_CMD_REFRESH, 2'h0, 12'h000, 1'b1, 8, 1'b1);
    check(refresh_count, c0 + 16'h1);
    $display("refused refresh done");
    c0 = refresh_count;
    go(LSD_CMD_REFRESH, 2'h0, 12'h000, 1'b0, 1300, 1'b0);
    check({self_refresh, refresh_count - c0 > 16'h1}, 2'h3);
    go(LSD_CMD_NOP, 2'h0, 12'h000, 1'b1, 2, 1'b0);
    check(self_refresh, 1'b0);
    $display("self refresh done");
    go(LSD_CMD_NOP, 2'h0, 12'h000, 1'b0, 4, 1'b0);
    check(power_down, 1'b1);
    c0 = refresh_count;
    go(LSD_CMD_NOP, 2'h0, 12'h000, 1'b1, 2, 1'b0);
    go(LSD_CMD_REFRESH, 2'h0, 12'h000, 1'b1, 0, 1'b0);
    check({power_down, refresh_busy, refresh_count}, {1'b0, 1'b1, c0 + 16'h1});
    $display("power-down done");
    complete_run();
  end
endmodule : lsd_sequencer_test
